//--- coa_defines.svh
// Constants for the operand addressing block
`ifndef COA_DEFINES_SVH
`define COA_DEFINES_SVH

// ----------------------------------------
// Instruction lengths in bytes
// ----------------------------------------
`define COA_LEN_TWO 2'h2
`define COA_LEN_THREE 2'h3

// ----------------------------------------
// Reset values and byte constants
// ----------------------------------------
`define COA_ACC_RST 8'h00
`define COA_IDX_RST 8'h00
`define COA_BYTE_ZERO 8'h00
`define COA_BYTE_ONE 8'h01

// ----------------------------------------
// Address space values of a memory request
// ----------------------------------------
`define COA_SPACE_RAM 1'b0
`define COA_SPACE_REG 1'b1

`endif

//--- coa_pkg.sv
// Types shared by the operand addressing block
package coa_pkg;

    // ----------------------------------------
    // Addressing modes
    // ----------------------------------------
    typedef enum logic [2:0] {
        COA_SRC_IDX = 3'h0,
        COA_DST_DIR = 3'h1,
        COA_DST_IDX = 3'h2,
        COA_DST_DIR_IMM = 3'h3,
        COA_DST_IDX_IMM = 3'h4,
        COA_DIR_DIR = 3'h5,
        COA_SRC_IND = 3'h6,
        COA_DST_IND = 3'h7
    } coa_mode_t;

    typedef enum logic [2:0] {
        COA_OP_MOV = 3'h0,
        COA_OP_ADD = 3'h1,
        COA_OP_AND = 3'h2,
        COA_OP_OR = 3'h3,
        COA_OP_XOR = 3'h4
    } coa_op_t;

    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        coa_mode_t mode;
        coa_op_t op;
        logic use_x;
        logic reg_space;
        logic [7:0] op1;
        logic [7:0] op2;
    } coa_cmd_t;

    typedef struct packed {
        logic valid;
        logic we;
        logic reg_space;
        logic bank;
        logic [7:0] addr;
        logic [7:0] wdata;
    } coa_mem_t;

    typedef struct packed {
        logic [1:0] len;
        logic legal;
        logic ind;
        logic use_idx;
        logic rd_first;
    } coa_dec_t;

endpackage

//--- coa_mode_dec.sv
// Addressing mode decoder: length, legality and read needs
`timescale 1ns/1ps
`include "coa_defines.svh"

module coa_mode_dec (
    input coa_pkg::coa_cmd_t cmd,
    output coa_pkg::coa_dec_t dec
);
    import coa_pkg::*;

    logic arith;

    always_comb begin
        arith = (cmd.op != COA_OP_MOV);
        dec = '0;
        dec.legal = 1'b1;
        unique case (cmd.mode)
            COA_SRC_IDX: begin
                dec.len = `COA_LEN_TWO;
                dec.use_idx = 1'b1;
                dec.rd_first = 1'b1;
            end
            COA_DST_DIR: begin
                dec.len = `COA_LEN_TWO;
                dec.rd_first = arith;
            end
            COA_DST_IDX: begin
                dec.len = `COA_LEN_TWO;
                dec.use_idx = 1'b1;
                dec.rd_first = arith;
            end
            COA_DST_DIR_IMM: begin
                dec.len = `COA_LEN_THREE;
                dec.rd_first = arith;
            end
            COA_DST_IDX_IMM: begin
                dec.len = `COA_LEN_THREE;
                dec.use_idx = 1'b1;
                dec.rd_first = arith;
            end
            COA_DIR_DIR: begin
                dec.len = `COA_LEN_THREE;
                dec.legal = !arith;
                dec.rd_first = 1'b1;
            end
            COA_SRC_IND, COA_DST_IND: begin
                dec.len = `COA_LEN_TWO;
                dec.legal = !arith;
                dec.ind = 1'b1;
            end
        endcase
    end

endmodule

//--- coa_addr_unit.sv
// Effective address former and pointer incrementer
`timescale 1ns/1ps
`include "coa_defines.svh"

module coa_addr_unit (
    input wire logic [7:0] base,
    input wire logic [7:0] idx,
    input wire logic use_idx,
    input wire logic [7:0] ptr,
    output logic [7:0] addr,
    output logic [7:0] ptr_inc
);
    import coa_pkg::*;

    // Carry out of bit 7 is dropped, so pages wrap
    function automatic logic [7:0] add8(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[7:0];
    endfunction

    always_comb begin
        addr = use_idx ? add8(base, idx) : base;
        ptr_inc = add8(ptr, `COA_BYTE_ONE);
    end

endmodule

//--- coa_core.sv
// Operand addressing sequencer of the 8-bit core
//
// Notes on behaviour
// - Source indexed reads op1+X and writes the named A or X.
// - Source indexed arithmetic takes first operand from A or X; two bytes.
// - Destination direct writes to op1 from A or X; two bytes.
// - Destination direct arithmetic reads op1 too; A and X stay unchanged.
// - Destination indexed writes op1+X from A; arithmetic reads there too.
// - Direct destination with immediate: three bytes, op2 is the source.
// - Indexed destination with immediate: three bytes, result at op1+X.
// - RAM to RAM copy from op2 to op1, move only, three bytes.
// - Indirect load reads pointer at op1, loads pointed byte into A.
// - Indirect store reads pointer at op1, stores A where it points.
// - Both indirect moves write the pointer back incremented.
// - Register-space operands send direct or indexed addresses to register space, except in the RAM to RAM copy.
// - Bank select flag chooses one of two register banks.
`timescale 1ns/1ps
`include "coa_defines.svh"

module coa_core (
    input wire logic mclk,
    input wire logic rst,
    input wire logic cmd_valid,
    input coa_pkg::coa_cmd_t cmd_in,
    input wire logic bank_select_flag,
    input wire logic ld_valid,
    input wire logic [7:0] ld_acc,
    input wire logic [7:0] ld_idx,
    input wire logic [7:0] mem_rdata,
    output logic cmd_ready,
    output logic done,
    output logic err,
    output logic [1:0] instr_len,
    output coa_pkg::coa_mem_t mem,
    output logic [7:0] acc,
    output logic [7:0] idx
);
    import coa_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_RD_PTR = 3'h1,
        ST_GET_PTR = 3'h2,
        ST_RD_DAT = 3'h3,
        ST_GET_DAT = 3'h4,
        ST_WR_RES = 3'h5,
        ST_WR_PTR = 3'h6
    } coa_st_t;

    typedef struct packed {
        coa_st_t st;
        coa_cmd_t cmd;
        logic bank;
        logic [1:0] len;
        logic [7:0] ptr;
        logic [7:0] acc;
        logic [7:0] idx;
        coa_mem_t mem;
        logic ready;
        logic done;
        logic err;
    } coa_state_t;

    coa_state_t s_reg;
    coa_state_t s_next;
    coa_cmd_t cur;
    coa_dec_t dec;
    logic [7:0] eff_addr;
    logic [7:0] ptr_inc;
    logic accept;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [7:0] alu(input coa_op_t op, input logic [7:0] a,
                                       input logic [7:0] b);
        logic [8:0] s;
        s = {1'b0, a} + {1'b0, b};
        unique case (op)
            COA_OP_MOV: return b;
            COA_OP_ADD: return s[7:0];
            COA_OP_AND: return a & b;
            COA_OP_OR: return a | b;
            COA_OP_XOR: return a ^ b;
            default: return b;
        endcase
    endfunction

    function automatic coa_mem_t mreq(input logic we, input logic rs, input logic bank,
                                      input logic [7:0] addr, input logic [7:0] wd);
        coa_mem_t m;
        m.valid = 1'b1;
        m.we = we;
        m.reg_space = rs;
        m.bank = rs ? bank : 1'b0;
        m.addr = addr;
        m.wdata = wd;
        return m;
    endfunction

    // ----------------------------------------
    // Decode and address forming
    // ----------------------------------------
    // The idle cycle decodes the incoming command so the first access issues at once
    assign accept = s_reg.ready && cmd_valid;
    assign cur = (s_reg.st == ST_IDLE) ? cmd_in : s_reg.cmd;

    coa_mode_dec u_dec (
        .cmd(cur),
        .dec(dec)
    );

    coa_addr_unit u_addr (
        .base(cur.op1),
        .idx(s_reg.idx),
        .use_idx(dec.use_idx),
        .ptr(s_reg.ptr),
        .addr(eff_addr),
        .ptr_inc(ptr_inc)
    );

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_comb begin
        logic [7:0] src;
        logic bank;
        src = 8'h00;
        bank = 1'b0;
        s_next = s_reg;
        s_next.done = 1'b0;
        s_next.err = 1'b0;
        s_next.mem.valid = 1'b0;
        s_next.mem.we = 1'b0;
        bank = (s_reg.st == ST_IDLE) ? bank_select_flag : s_reg.bank;
        // source A or X for direct
        unique case (cur.mode)
            COA_DST_DIR: src = cur.use_x ? s_reg.idx : s_reg.acc;
            COA_DST_DIR_IMM, COA_DST_IDX_IMM: src = cur.op2;
            default: src = s_reg.acc;
        endcase
        unique case (s_reg.st)
            ST_IDLE: begin
                if (accept && !dec.legal) begin
                    s_next.err = 1'b1;
                end else if (accept) begin
                    s_next.cmd = cmd_in;
                    s_next.bank = bank_select_flag;
                    s_next.len = dec.len;
                    s_next.ready = 1'b0;
                    if (dec.ind) begin
                        s_next.mem = mreq(1'b0, `COA_SPACE_RAM, 1'b0, cur.op1,
                                          `COA_BYTE_ZERO);
                        s_next.st = ST_RD_PTR;
                    end else if (cur.mode == COA_DIR_DIR) begin
                        s_next.mem = mreq(1'b0, `COA_SPACE_RAM, 1'b0, cur.op2,
                                          `COA_BYTE_ZERO);
                        s_next.st = ST_RD_DAT;
                    end else if (dec.rd_first) begin
                        s_next.mem = mreq(1'b0, cur.reg_space, bank, eff_addr,
                                          `COA_BYTE_ZERO);
                        s_next.st = ST_RD_DAT;
                    end else begin
                        s_next.mem = mreq(1'b1, cur.reg_space, bank, eff_addr, src);
                        s_next.st = ST_WR_RES;
                    end
                end else if (ld_valid) begin
                    s_next.acc = ld_acc;
                    s_next.idx = ld_idx;
                end
            end
            ST_RD_PTR: s_next.st = ST_GET_PTR;
            ST_GET_PTR: begin
                s_next.ptr = mem_rdata;
                if (cur.mode == COA_SRC_IND) begin
                    s_next.mem = mreq(1'b0, `COA_SPACE_RAM, 1'b0, mem_rdata,
                                      `COA_BYTE_ZERO);
                    s_next.st = ST_RD_DAT;
                end else begin
                    s_next.mem = mreq(1'b1, `COA_SPACE_RAM, 1'b0, mem_rdata, s_reg.acc);
                    s_next.st = ST_WR_RES;
                end
            end
            ST_RD_DAT: s_next.st = ST_GET_DAT;
            ST_GET_DAT: begin
                unique case (cur.mode)
                    COA_SRC_IDX: begin
                        // first operand is the named register
                        if (cur.use_x) begin
                            s_next.idx = alu(cur.op, s_reg.idx, mem_rdata);
                        end else begin
                            s_next.acc = alu(cur.op, s_reg.acc, mem_rdata);
                        end
                        s_next.st = ST_IDLE;
                        s_next.ready = 1'b1;
                        s_next.done = 1'b1;
                    end
                    COA_SRC_IND: begin
                        s_next.acc = mem_rdata;
                        s_next.mem = mreq(1'b1, `COA_SPACE_RAM, 1'b0, cur.op1, ptr_inc);
                        s_next.st = ST_WR_PTR;
                    end
                    COA_DIR_DIR: begin
                        s_next.mem = mreq(1'b1, `COA_SPACE_RAM, 1'b0, cur.op1, mem_rdata);
                        s_next.st = ST_WR_RES;
                    end
                    default: begin
                        // location is first source, registers kept
                        s_next.mem = mreq(1'b1, cur.reg_space, bank, eff_addr,
                                          alu(cur.op, mem_rdata, src));
                        s_next.st = ST_WR_RES;
                    end
                endcase
            end
            ST_WR_RES: begin
                if (cur.mode == COA_DST_IND) begin
                    s_next.mem = mreq(1'b1, `COA_SPACE_RAM, 1'b0, cur.op1, ptr_inc);
                    s_next.st = ST_WR_PTR;
                end else begin
                    s_next.st = ST_IDLE;
                    s_next.ready = 1'b1;
                    s_next.done = 1'b1;
                end
            end
            ST_WR_PTR: begin
                s_next.st = ST_IDLE;
                s_next.ready = 1'b1;
                s_next.done = 1'b1;
            end
            default: begin
                s_next.st = ST_IDLE;
                s_next.ready = 1'b1;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            s_reg <= '0;
            s_reg.st <= ST_IDLE;
            s_reg.ready <= 1'b1;
            s_reg.acc <= `COA_ACC_RST;
            s_reg.idx <= `COA_IDX_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    assign cmd_ready = s_reg.ready;
    assign done = s_reg.done;
    assign err = s_reg.err;
    assign instr_len = s_reg.len;
    assign mem = s_reg.mem;
    assign acc = s_reg.acc;
    assign idx = s_reg.idx;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    src_idx_addr_a: assert property (
        accept && dec.legal && cmd_in.mode == COA_SRC_IDX |=> mem.valid && !mem.we
        && mem.addr == 8'($past(cmd_in.op1) + $past(s_reg.idx)))
        else $error("source indexed address wrong");
    two_byte_len_a: assert property (
        accept && dec.legal && cmd_in.mode inside {COA_SRC_IDX, COA_DST_DIR, COA_DST_IDX}
        |=> instr_len == `COA_LEN_TWO)
        else $error("two byte length wrong");
    dst_dir_wr_a: assert property (
        accept && cmd_in.mode == COA_DST_DIR && cmd_in.op == COA_OP_MOV
        |=> mem.we && mem.addr == $past(cmd_in.op1))
        else $error("destination direct write wrong");
    regs_kept_a: assert property (
        s_reg.st inside {ST_RD_DAT, ST_GET_DAT, ST_WR_RES} && s_reg.cmd.mode == COA_DST_DIR
        |=> $stable(acc) && $stable(idx))
        else $error("source register changed");
    three_byte_len_a: assert property (
        accept && dec.legal && cmd_in.mode inside {COA_DST_DIR_IMM, COA_DST_IDX_IMM,
        COA_DIR_DIR} |=> instr_len == `COA_LEN_THREE)
        else $error("three byte length wrong");
    move_only_a: assert property (
        accept && cmd_in.mode == COA_DIR_DIR && cmd_in.op != COA_OP_MOV |=> err && cmd_ready)
        else $error("illegal copy accepted");
    ind_load_a: assert property (
        s_reg.st == ST_GET_DAT && s_reg.cmd.mode == COA_SRC_IND |=> acc == $past(mem_rdata))
        else $error("indirect load wrong");
    ind_store_a: assert property (
        s_reg.st == ST_WR_RES && s_reg.cmd.mode == COA_DST_IND
        |-> mem.we && mem.addr == s_reg.ptr && mem.wdata == acc)
        else $error("indirect store wrong");
    ptr_inc_a: assert property (
        s_reg.st == ST_WR_PTR |-> mem.we && mem.addr == s_reg.cmd.op1
        && mem.wdata == 8'(s_reg.ptr + 8'h01) ##1 done)
        else $error("pointer write back wrong");
    space_bank_a: assert property (
        mem.valid && mem.reg_space |-> s_reg.cmd.reg_space && mem.bank == s_reg.bank)
        else $error("register space or bank wrong");

    cov_src_idx_c: cover property (accept && cmd_in.mode == COA_SRC_IDX ##[1:4] done);
    cov_copy_c: cover property (accept && cmd_in.mode == COA_DIR_DIR ##[1:6] done);
    cov_ind_c: cover property (s_reg.st == ST_WR_PTR && s_reg.ptr == 8'hFF);
    cov_bank_c: cover property (mem.valid && mem.reg_space && mem.bank);

endmodule

//--- coa_core_test.sv
// Self-checking testbench for the operand addressing sequencer
`timescale 1ns/1ps

`define CHK(nm, exp, got) begin \
    n_tests++; \
    if ((got) !== (exp)) begin \
        mismatches++; \
        $display("unexpected %s: expected %0h seen %0h", nm, exp, got); \
    end \
end

module coa_core_test;
    import coa_pkg::*;

    logic mclk, rst, cmd_valid, bank_select_flag, ld_valid;
    coa_cmd_t cmd_in;
    logic [7:0] ld_acc, ld_idx, mem_rdata;
    logic cmd_ready, done, err;
    logic [1:0] instr_len;
    coa_mem_t mem;
    logic [7:0] acc, idx;
    int mismatches, n_tests, cycles;
    logic [7:0] ram [0:255];
    logic [7:0] rg [0:511];

    coa_core coa_core_inst (
        .mclk(mclk), .rst(rst), .cmd_valid(cmd_valid), .cmd_in(cmd_in),
        .bank_select_flag(bank_select_flag), .ld_valid(ld_valid), .ld_acc(ld_acc),
        .ld_idx(ld_idx), .mem_rdata(mem_rdata), .cmd_ready(cmd_ready), .done(done),
        .err(err), .instr_len(instr_len), .mem(mem), .acc(acc), .idx(idx)
    );

    // ----------------------------------------
    // Clock, memory and timeout
    // ----------------------------------------
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // Idle read data toggles so a late sample never looks valid
    always @(posedge mclk) begin
        if (mem.valid && mem.we) begin
            if (mem.reg_space) rg[{mem.bank, mem.addr}] <= mem.wdata;
            else ram[mem.addr] <= mem.wdata;
        end
        if (mem.valid && !mem.we)
            mem_rdata <= mem.reg_space ? rg[{mem.bank, mem.addr}] : ram[mem.addr];
        else
            mem_rdata <= ~mem_rdata;
    end

    // Whole run needs well under a thousand cycles
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches++;
            end_of_test();
        end
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    function automatic coa_cmd_t mk(coa_mode_t m, coa_op_t o, logic ux, logic rs,
                                    logic [7:0] a, logic [7:0] b);
        return '{m, o, ux, rs, a, b};
    endfunction

    // Inputs are scrambled after the take edge: the command must be captured
    task automatic run(input coa_cmd_t c, input logic b, input int lat, input string nm);
        int n;
        n = 0;
        @(posedge mclk);
        cmd_in <= c;
        cmd_valid <= 1'b1;
        bank_select_flag <= b;
        @(posedge mclk);
        cmd_valid <= 1'b0;
        bank_select_flag <= ~b;
        cmd_in <= ~c;
        do begin
            @(negedge mclk);
            n++;
        end while (!(done === 1'b1 || err === 1'b1) && n < 20);
        `CHK({nm, " latency"}, lat, n)
    endtask

    task automatic load(input logic [7:0] a, input logic [7:0] x);
        @(posedge mclk);
        ld_valid <= 1'b1;
        ld_acc <= a;
        ld_idx <= x;
        @(posedge mclk);
        ld_valid <= 1'b0;
        @(negedge mclk);
        `CHK("acc load", a, acc)
        `CHK("idx load", x, idx)
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        @(negedge mclk);
        `CHK("ready", 1'b1, cmd_ready)
        `CHK("acc", 8'h00, acc)
        `CHK("idx", 8'h00, idx)
        `CHK("len", 2'h0, instr_len)
        `CHK("mem valid", 1'b0, mem.valid)
        $display("test reset done");
    endtask

    task automatic t_src_idx();
        load(8'h11, 8'hF0);
        ram[8'h10] = 8'h22;
        run(mk(COA_SRC_IDX, COA_OP_ADD, 1'b0, 1'b0, 8'h20, 8'h00), 1'b0, 3, "src add");
        `CHK("src add acc", 8'h33, acc)
        `CHK("src len", 2'h2, instr_len)
        rg[9'h118] = 8'h77;
        rg[9'h018] = 8'h66;
        run(mk(COA_SRC_IDX, COA_OP_MOV, 1'b1, 1'b1, 8'h28, 8'h00), 1'b1, 3, "src reg");
        `CHK("src reg idx", 8'h77, idx)
        `CHK("src reg acc", 8'h33, acc)
        $display("test source indexed done");
    endtask

    task automatic t_dst_dir();
        ram[8'h40] = 8'h05;
        run(mk(COA_DST_DIR, COA_OP_ADD, 1'b0, 1'b0, 8'h40, 8'h00), 1'b0, 4, "dst add");
        `CHK("dst add ram", 8'h38, ram[8'h40])
        `CHK("dst add acc", 8'h33, acc)
        `CHK("dst len", 2'h2, instr_len)
        run(mk(COA_DST_DIR, COA_OP_MOV, 1'b1, 1'b1, 8'h41, 8'h00), 1'b0, 2, "dst mov");
        `CHK("dst mov reg", 8'h77, rg[9'h041])
        `CHK("dst mov idx", 8'h77, idx)
        $display("test destination direct done");
    endtask

    task automatic t_dst_idx();
        ram[8'h07] = 8'h10;
        run(mk(COA_DST_IDX, COA_OP_ADD, 1'b1, 1'b0, 8'h90, 8'h00), 1'b0, 4, "dix add");
        `CHK("dix add ram", 8'h43, ram[8'h07])
        `CHK("dix len", 2'h2, instr_len)
        $display("test destination indexed done");
    endtask

    task automatic t_imm();
        ram[8'h50] = 8'hF0;
        ram[8'h51] = 8'h3C;
        ram[8'h97] = 8'h01;
        run(mk(COA_DST_DIR_IMM, COA_OP_XOR, 1'b0, 1'b0, 8'h50, 8'h0F), 1'b0, 4, "imm xor");
        `CHK("imm xor ram", 8'hFF, ram[8'h50])
        `CHK("imm len", 2'h3, instr_len)
        run(mk(COA_DST_DIR_IMM, COA_OP_AND, 1'b0, 1'b0, 8'h51, 8'h0F), 1'b0, 4, "imm and");
        `CHK("imm and ram", 8'h0C, ram[8'h51])
        run(mk(COA_DST_IDX_IMM, COA_OP_OR, 1'b0, 1'b0, 8'h20, 8'h80), 1'b0, 4, "ixm or");
        `CHK("ixm or ram", 8'h81, ram[8'h97])
        run(mk(COA_DST_IDX_IMM, COA_OP_MOV, 1'b0, 1'b1, 8'h10, 8'hAB), 1'b1, 2, "ixm mov");
        `CHK("ixm mov reg", 8'hAB, rg[9'h187])
        `CHK("ixm len", 2'h3, instr_len)
        $display("test immediate done");
    endtask

    task automatic t_copy();
        ram[8'h60] = 8'h5E;
        ram[8'h61] = 8'h00;
        run(mk(COA_DIR_DIR, COA_OP_MOV, 1'b0, 1'b0, 8'h61, 8'h60), 1'b0, 4, "copy");
        `CHK("copy ram", 8'h5E, ram[8'h61])
        `CHK("copy len", 2'h3, instr_len)
        run(mk(COA_DIR_DIR, COA_OP_ADD, 1'b0, 1'b0, 8'h61, 8'h60), 1'b0, 1, "copy add");
        `CHK("copy add ram", 8'h5E, ram[8'h61])
        ram[8'h62] = 8'h44;
        run(mk(COA_SRC_IND, COA_OP_ADD, 1'b0, 1'b0, 8'h62, 8'h00), 1'b0, 1, "ind add");
        `CHK("ind add ptr", 8'h44, ram[8'h62])
        run(mk(COA_DST_IND, COA_OP_OR, 1'b0, 1'b0, 8'h62, 8'h00), 1'b0, 1, "ind or");
        `CHK("ind or ptr", 8'h44, ram[8'h62])
        `CHK("ind or acc", 8'h33, acc)
        $display("test copy and refusals done");
    endtask

    task automatic t_ind();
        ram[8'h70] = 8'hFF;
        ram[8'hFF] = 8'h9C;
        run(mk(COA_SRC_IND, COA_OP_MOV, 1'b0, 1'b0, 8'h70, 8'h00), 1'b0, 6, "ind load");
        `CHK("ind load acc", 8'h9C, acc)
        `CHK("ind load ptr", 8'h00, ram[8'h70])
        `CHK("ind load len", 2'h2, instr_len)
        ram[8'h71] = 8'h30;
        run(mk(COA_DST_IND, COA_OP_MOV, 1'b0, 1'b0, 8'h71, 8'h00), 1'b0, 5, "ind store");
        `CHK("ind store ram", 8'h9C, ram[8'h30])
        `CHK("ind store ptr", 8'h31, ram[8'h71])
        $display("test indirect done");
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rst = 1'b1;
        cmd_valid = 1'b0;
        cmd_in = '0;
        bank_select_flag = 1'b0;
        ld_valid = 1'b0;
        ld_acc = 8'h00;
        ld_idx = 8'h00;
        mem_rdata = 8'h00;
        mismatches = 0;
        n_tests = 0;
        cycles = 0;
        for (int i = 0; i < 512; i++) begin
            rg[i] = 8'(i) ^ 8'hC3;
            if (i < 256) ram[i] = 8'(i) ^ 8'hA5;
        end
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        t_reset();
        t_src_idx();
        t_dst_dir();
        t_dst_idx();
        t_imm();
        t_copy();
        t_ind();
        end_of_test();
    end
endmodule
